// ===== eqcr_regs.sv
// Contract
// - General control bit 7 reads carrier presence, read-only.
// - Mute bit mutes outputs, resets to 0, overrides bypass.
// - Bypass bit routes around the equalizer; resets to 0.
// - Sleep field: 00 on, 01 auto sleep (reset), 10 forced down, 11 reserved.
// - Active sleep overrides both mute and bypass.
// - Master reset bit resets registers and adaptation, self-clears.
// - Acquisition reset bit resets adaptation only, self-clears.
// - Driver bits 7:6 select swing 400/600/700/800 mV, reset 10.
// - Driver bits 5:4 select common mode 0.8/1.0/1.2 V/supply, reset 10.
// - Driver bit 3 enables de-emphasis, resets to 0.
// - Driver bits 2:1 de-emphasis depth, reset 01; bit 0 reads 0.
// - Launch bit 7 selects 6 dB attenuation optimisation, reset 0.
// - Threshold bit 5 selects pin reference or digital threshold.
// - Digital threshold mutes at cable length code steps of 10 m; 11111 never.
// - Cable length register reads the 8-bit length code.
// - Launch level bits 7:2 report deviation, 100000 nominal.
// - Frame is direction bit, seven address bits, eight data bits.
// - Writes take effect only after select returns high.
`include "eqcr_params.svh"

module eqcr_regs #(
	parameter logic [1:0] FAMILY_VARIANT_FIELD = 2'b10, // Arbitrary value
	parameter logic [3:0] REVISION_FIELD       = 4'h5   // Arbitrary value
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Serial host port
	input  wire logic       spi_sck,
	input  wire logic       spi_ss_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	// Analogue status
	input  wire logic       carrier_detect,
	input  wire logic       rate_is_hd,
	input  wire logic [7:0] cable_length_code,
	input  wire logic [5:0] launch_level_code,
	input  wire logic       mute_ref_pin_mute,
	// Signal path control
	output logic            out_mute,
	output logic            eq_bypass,
	output logic            eq_sleep,
	output logic            adapt_reset,
	// Driver and input settings
	output logic      [1:0] output_swing_sel,
	output logic      [1:0] output_common_mode_level,
	output logic            deemph_en,
	output logic      [1:0] deemph_level,
	output logic            launch_atten_sel
);

	logic                 mute_reg;
	logic                 bypass_reg;
	eqcr_pkg::eqcr_sleep_t sleep_reg;
	logic [7:0]           drv_reg;
	logic [7:0]           launch_reg;
	logic [7:0]           thr_reg;
	logic [7:0]           rd_data;
	logic [6:0]           cur_addr;
	logic                 frame_stb;
	logic                 frame_wr;
	logic [6:0]           frame_addr;
	logic [7:0]           frame_data;
	logic                 wr_stb;
	logic                 wr_gen;
	logic                 wr_master;
	logic                 wr_acq;
	logic                 sleep_now;
	logic                 thr_mute;
	logic [5:0]           thr_plus1;
	logic [8:0]           thr_limit;

	eqcr_spi_frame u_frame (
		.core_clk   (core_clk),
		.rst        (rst),
		.spi_sck    (spi_sck),
		.spi_ss_n   (spi_ss_n),
		.spi_mosi   (spi_mosi),
		.spi_miso   (spi_miso),
		.rd_data    (rd_data),
		.cur_addr   (cur_addr),
		.frame_stb  (frame_stb),
		.frame_wr   (frame_wr),
		.frame_addr (frame_addr),
		.frame_data (frame_data)
	);

	// Write decode
	assign wr_stb    = frame_stb & frame_wr;
	assign wr_gen    = wr_stb & (frame_addr == `EQCR_ADDR_GEN);
	assign wr_master = wr_gen & frame_data[`EQCR_GEN_MRST_BIT];
	assign wr_acq    = wr_gen & frame_data[`EQCR_GEN_ARST_BIT];

	// General control storage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mute_reg   <= `EQCR_RST_MUTE;
			bypass_reg <= `EQCR_RST_BYPASS;
			sleep_reg  <= eqcr_pkg::EQCR_SLEEP_AUTO;
		end else if (wr_master) begin
			mute_reg   <= `EQCR_RST_MUTE;
			bypass_reg <= `EQCR_RST_BYPASS;
			sleep_reg  <= eqcr_pkg::EQCR_SLEEP_AUTO;
		end else if (wr_gen) begin
			mute_reg   <= frame_data[`EQCR_GEN_MUTE_BIT];
			bypass_reg <= frame_data[`EQCR_GEN_BYPASS_BIT];
			sleep_reg  <= eqcr_pkg::eqcr_sleep_t'(frame_data[`EQCR_GEN_SLEEP_HI:`EQCR_GEN_SLEEP_LO]);
		end
	end

	// Driver, launch and threshold storage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			drv_reg    <= `EQCR_RST_DRV;
			launch_reg <= `EQCR_RST_LAUNCH;
			thr_reg    <= `EQCR_RST_THR;
		end else if (wr_master) begin
			drv_reg    <= `EQCR_RST_DRV;
			launch_reg <= `EQCR_RST_LAUNCH;
			thr_reg    <= `EQCR_RST_THR;
		end else if (wr_stb) begin
			case (frame_addr)
				`EQCR_ADDR_DRV: begin
					drv_reg <= {frame_data[7:1], 1'b0};
				end
				`EQCR_ADDR_LAUNCH: begin
					launch_reg <= frame_data;
				end
				`EQCR_ADDR_THR: begin
					thr_reg <= frame_data;
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux for the addressed register
	always_comb begin
		case (cur_addr)
			`EQCR_ADDR_GEN:    rd_data = {carrier_detect, mute_reg, bypass_reg, sleep_reg, 3'b000};
			`EQCR_ADDR_DRV:    rd_data = {drv_reg[7:1], 1'b0};
			`EQCR_ADDR_LAUNCH: rd_data = launch_reg;
			`EQCR_ADDR_THR:    rd_data = thr_reg;
			`EQCR_ADDR_ID:     rd_data = {2'b00, FAMILY_VARIANT_FIELD, REVISION_FIELD};
			`EQCR_ADDR_RATE:   rd_data = {2'b00, rate_is_hd, `EQCR_RATE_RSVD};
			`EQCR_ADDR_CABLE:  rd_data = cable_length_code;
			`EQCR_ADDR_LEVEL:  rd_data = {launch_level_code, 2'b00};
			default:           rd_data = 8'h00;
		endcase
	end

	// Cable length threshold, code units of 1.25 m
	assign thr_plus1 = {1'b0, thr_reg[`EQCR_THR_HI:`EQCR_THR_LO]} + 6'h01;
	assign thr_limit = {thr_plus1, 3'b000};

	always_comb begin
		if (thr_reg[`EQCR_THR_MODE_BIT]) begin
			thr_mute = (thr_reg[`EQCR_THR_HI:`EQCR_THR_LO] != `EQCR_THR_NEVER)
			           && ({1'b0, cable_length_code} >= thr_limit);
		end else begin
			thr_mute = mute_ref_pin_mute;
		end
	end

	// Sleep decision
	always_comb begin
		case (sleep_reg)
			eqcr_pkg::EQCR_SLEEP_AUTO:  sleep_now = ~carrier_detect;
			eqcr_pkg::EQCR_SLEEP_FORCE: sleep_now = 1'b1;
			default:                    sleep_now = 1'b0;
		endcase
	end

	// Output state, sleep then mute then bypass
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			eq_sleep  <= 1'b0;
			out_mute  <= 1'b0;
			eq_bypass <= 1'b0;
		end else begin
			eq_sleep  <= sleep_now;
			out_mute  <= ~sleep_now & (mute_reg | thr_mute);
			eq_bypass <= ~sleep_now & ~mute_reg & bypass_reg;
		end
	end

	// Adaptation reset pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			adapt_reset <= 1'b0;
		end else begin
			adapt_reset <= wr_master | wr_acq;
		end
	end

	// Driver and launch settings
	assign output_swing_sel         = drv_reg[`EQCR_DRV_SWING_HI:`EQCR_DRV_SWING_LO];
	assign output_common_mode_level = drv_reg[`EQCR_DRV_CM_HI:`EQCR_DRV_CM_LO];
	assign deemph_en                = drv_reg[`EQCR_DRV_DE_EN_BIT];
	assign deemph_level             = drv_reg[`EQCR_DRV_DE_HI:`EQCR_DRV_DE_LO];
	assign launch_atten_sel         = launch_reg[`EQCR_LAUNCH_ATT_BIT];

	carrier_bit_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_addr == `EQCR_ADDR_GEN) |-> (rd_data[7] == carrier_detect && rd_data[2:0] == 3'b000))
		else $error("general control read shows wrong carrier or fixed bits");

	mute_over_bypass_a: assert property (@(posedge core_clk) disable iff (rst)
		(mute_reg && !sleep_now) |=> (out_mute && !eq_bypass))
		else $error("mute did not override bypass");

	bypass_path_a: assert property (@(posedge core_clk) disable iff (rst)
		(bypass_reg && !mute_reg && !sleep_now) |=> eq_bypass)
		else $error("bypass not applied");

	sleep_force_a: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_reg == eqcr_pkg::EQCR_SLEEP_FORCE) |=> eq_sleep)
		else $error("forced sleep not applied");

	sleep_auto_a: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_reg == eqcr_pkg::EQCR_SLEEP_AUTO) |=> (eq_sleep == !$past(carrier_detect)))
		else $error("auto sleep does not follow carrier");

	sleep_first_a: assert property (@(posedge core_clk) disable iff (rst)
		eq_sleep |-> (!out_mute && !eq_bypass))
		else $error("output active while asleep");

	master_reset_a: assert property (@(posedge core_clk) disable iff (rst)
		wr_master |=> (adapt_reset && drv_reg == `EQCR_RST_DRV && launch_reg == `EQCR_RST_LAUNCH
		               && thr_reg == `EQCR_RST_THR && sleep_reg == eqcr_pkg::EQCR_SLEEP_AUTO && !mute_reg))
		else $error("master reset did not restore defaults");

	acq_reset_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_acq && !wr_master) |=> (adapt_reset && $stable(drv_reg) && $stable(thr_reg)) ##1 !adapt_reset)
		else $error("acquisition reset pulse or register hold wrong");

	driver_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_stb && frame_addr == `EQCR_ADDR_DRV) |=> (drv_reg == {$past(frame_data[7:1]), 1'b0}))
		else $error("driver register write not stored");

	thr_never_a: assert property (@(posedge core_clk) disable iff (rst)
		(thr_reg[`EQCR_THR_MODE_BIT] && thr_reg[4:0] == `EQCR_THR_NEVER && !mute_reg) |=> !out_mute)
		else $error("never-mute threshold muted");

	write_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		!frame_stb |=> ($stable(drv_reg) && $stable(launch_reg) && $stable(thr_reg) && $stable(sleep_reg)))
		else $error("register changed without a completed frame");

	gen_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_gen && !wr_master) |=> (sleep_reg == $past(frame_data[`EQCR_GEN_SLEEP_HI:`EQCR_GEN_SLEEP_LO])
		                            && mute_reg == $past(frame_data[`EQCR_GEN_MUTE_BIT])
		                            && bypass_reg == $past(frame_data[`EQCR_GEN_BYPASS_BIT])))
		else $error("general control write not stored");

	launch_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_stb && frame_addr == `EQCR_ADDR_LAUNCH) |=> (launch_reg == $past(frame_data)))
		else $error("launch register write not stored");

	thr_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_stb && frame_addr == `EQCR_ADDR_THR) |=> (thr_reg == $past(frame_data)))
		else $error("threshold register write not stored");

	ro_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(wr_stb && frame_addr >= `EQCR_ADDR_ID) |=> ($stable(drv_reg) && $stable(launch_reg) && $stable(thr_reg)
		                                            && $stable(sleep_reg) && $stable(mute_reg)))
		else $error("write to a read-only address changed a register");

	adapt_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		adapt_reset |=> !adapt_reset)
		else $error("adaptation reset longer than one cycle");

	adapt_source_a: assert property (@(posedge core_clk) disable iff (rst)
		adapt_reset |-> ($past(wr_master) || $past(wr_acq)))
		else $error("adaptation reset without a reset write");

	sleep_off_a: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_reg == eqcr_pkg::EQCR_SLEEP_OFF) |=> !eq_sleep)
		else $error("sleep while sleep disabled");

	sleep_rsvd_a: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_reg == eqcr_pkg::EQCR_SLEEP_RSVD) |=> !eq_sleep)
		else $error("sleep on reserved sleep code");

	pin_mute_a: assert property (@(posedge core_clk) disable iff (rst)
		(!thr_reg[`EQCR_THR_MODE_BIT] && mute_ref_pin_mute && !sleep_now) |=> out_mute)
		else $error("pin mute request not applied");

	thr_reach_a: assert property (@(posedge core_clk) disable iff (rst)
		(thr_reg[`EQCR_THR_MODE_BIT] && thr_reg[`EQCR_THR_HI:`EQCR_THR_LO] == 5'h00
		 && cable_length_code >= 8'h08 && !sleep_now) |=> out_mute)
		else $error("lowest threshold reached without mute");

	thr_short_a: assert property (@(posedge core_clk) disable iff (rst)
		(thr_reg[`EQCR_THR_MODE_BIT] && !mute_reg && cable_length_code < 8'h08 && !sleep_now) |=> !out_mute)
		else $error("short cable muted by threshold");

	level_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_addr == `EQCR_ADDR_LEVEL) |-> (rd_data == {launch_level_code, 2'b00}))
		else $error("launch level read wrong");

	unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_addr > `EQCR_ADDR_LEVEL) |-> (rd_data == 8'h00))
		else $error("unmapped address read not zero");

endmodule

// ===== eqcr_params.svh
`ifndef EQCR_PARAMS_SVH
`define EQCR_PARAMS_SVH

// Register addresses (7-bit frame address)
`define EQCR_ADDR_GEN       7'h00
`define EQCR_ADDR_DRV       7'h01
`define EQCR_ADDR_LAUNCH    7'h02
`define EQCR_ADDR_THR       7'h03
`define EQCR_ADDR_ID        7'h04
`define EQCR_ADDR_RATE      7'h05
`define EQCR_ADDR_CABLE     7'h06
`define EQCR_ADDR_LEVEL     7'h07

// General control fields
`define EQCR_GEN_CARRIER_BIT 7
`define EQCR_GEN_MUTE_BIT    6
`define EQCR_GEN_BYPASS_BIT  5
`define EQCR_GEN_SLEEP_HI    4
`define EQCR_GEN_SLEEP_LO    3
`define EQCR_GEN_MRST_BIT    1
`define EQCR_GEN_ARST_BIT    0

// Output driver fields
`define EQCR_DRV_SWING_HI   7
`define EQCR_DRV_SWING_LO   6
`define EQCR_DRV_CM_HI      5
`define EQCR_DRV_CM_LO      4
`define EQCR_DRV_DE_EN_BIT  3
`define EQCR_DRV_DE_HI      2
`define EQCR_DRV_DE_LO      1

// Launch amplitude and mute threshold fields
`define EQCR_LAUNCH_ATT_BIT 7
`define EQCR_THR_MODE_BIT   5
`define EQCR_THR_HI         4
`define EQCR_THR_LO         0

// Reset values
`define EQCR_RST_MUTE       1'b0
`define EQCR_RST_BYPASS     1'b0
`define EQCR_RST_DRV        8'ha2
`define EQCR_RST_LAUNCH     8'h68
`define EQCR_RST_THR        8'h1f
`define EQCR_THR_NEVER      5'h1f
`define EQCR_RATE_RSVD      5'h18

// Frame layout
`define EQCR_FRAME_BITS     16
`define EQCR_FRAME_DIR_BIT  15
`define EQCR_FRAME_LAST     4'hf

`endif

// ===== eqcr_pkg.sv
package eqcr_pkg;

	typedef enum logic [1:0] {
		EQCR_SLEEP_OFF   = 2'b00,
		EQCR_SLEEP_AUTO  = 2'b01,
		EQCR_SLEEP_FORCE = 2'b10,
		EQCR_SLEEP_RSVD  = 2'b11
	} eqcr_sleep_t;

endpackage

// ===== eqcr_spi_frame.sv
`include "eqcr_params.svh"

module eqcr_spi_frame (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Serial pins
	input  wire logic       spi_sck,
	input  wire logic       spi_ss_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	// Read data for the addressed register
	input  wire logic [7:0] rd_data,
	output logic      [6:0] cur_addr,
	// Completed frame
	output logic            frame_stb,
	output logic            frame_wr,
	output logic      [6:0] frame_addr,
	output logic      [7:0] frame_data
);

	logic        sck_q;
	logic        ss_q;
	logic [15:0] shift_reg;
	logic [3:0]  bit_cnt;
	logic        seen_full;
	logic        sck_rise;
	logic        ss_rise;
	logic        ss_fall;
	logic        frame_ok;

	assign sck_rise = spi_sck & ~sck_q & ~spi_ss_n;
	assign ss_rise  = spi_ss_n & ~ss_q;
	assign ss_fall  = ~spi_ss_n & ss_q;
	assign frame_ok = seen_full & (bit_cnt == 4'h0);
	assign cur_addr = shift_reg[14:8];

	// Edge detect
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sck_q <= 1'b0;
			ss_q  <= 1'b1;
		end else begin
			sck_q <= spi_sck;
			ss_q  <= spi_ss_n;
		end
	end

	// Shift chain, read data latched at frame end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_reg <= 16'h0000;
		end else if (sck_rise) begin
			shift_reg <= {shift_reg[14:0], spi_mosi};
		end else if (ss_rise && frame_ok && shift_reg[`EQCR_FRAME_DIR_BIT]) begin
			shift_reg[7:0] <= rd_data;
		end
	end

	// Bit counting in whole frames
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bit_cnt   <= 4'h0;
			seen_full <= 1'b0;
		end else if (ss_fall) begin
			bit_cnt   <= 4'h0;
			seen_full <= 1'b0;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
			if (bit_cnt == `EQCR_FRAME_LAST) begin
				seen_full <= 1'b1;
			end
		end
	end

	// Frame hand-off on select release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frame_stb  <= 1'b0;
			frame_wr   <= 1'b0;
			frame_addr <= 7'h00;
			frame_data <= 8'h00;
		end else begin
			frame_stb <= ss_rise & frame_ok;
			if (ss_rise) begin
				frame_wr   <= ~shift_reg[`EQCR_FRAME_DIR_BIT];
				frame_addr <= shift_reg[14:8];
				frame_data <= shift_reg[7:0];
			end
		end
	end

	// Serial out
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			spi_miso <= 1'b0;
		end else begin
			spi_miso <= shift_reg[`EQCR_FRAME_DIR_BIT];
		end
	end

	frame_len_a: assert property (@(posedge core_clk) disable iff (rst)
		(ss_rise && bit_cnt != 4'h0) |=> !frame_stb)
		else $error("frame taken with a partial bit count");

endmodule

// ===== eqcr_host_model.sv
module eqcr_host_model (
	// Clock
	input  wire logic core_clk,
	// Serial pins
	output logic      spi_sck,
	output logic      spi_ss_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		spi_sck  = 1'b0;
		spi_ss_n = 1'b1;
		spi_mosi = 1'b1;
	end

	// Select falls while the clock line is low
	task automatic sel();
		@(posedge core_clk);
		spi_ss_n <= 1'b0;
		spi_mosi <= ~spi_mosi;
	endtask

	// MSB first, data set while clock line is low, return bit taken before each rise
	task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		for (i = n - 1; i >= 0; i--) begin
			@(posedge core_clk);
			spi_mosi <= tx[i];
			repeat (3) @(posedge core_clk);
			rx[i] = spi_miso;
			spi_sck <= 1'b1;
			repeat (4) @(posedge core_clk);
			spi_sck <= 1'b0;
		end
	endtask

	// Select returns high, data line no longer holds its last value
	task automatic desel();
		repeat (4) @(posedge core_clk);
		spi_ss_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		repeat (4) @(posedge core_clk);
	endtask
endmodule

// ===== tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk;
	logic       rst;
	logic       spi_sck;
	logic       spi_ss_n;
	logic       spi_mosi;
	logic       spi_miso;
	logic       carrier_detect;
	logic       rate_is_hd;
	logic [7:0] cable_length_code;
	logic [5:0] launch_level_code;
	logic       mute_ref_pin_mute;
	logic       out_mute;
	logic       eq_bypass;
	logic       eq_sleep;
	logic       adapt_reset;
	logic [1:0] output_swing_sel;
	logic [1:0] output_common_mode_level;
	logic       deemph_en;
	logic [1:0] deemph_level;
	logic       launch_atten_sel;
	logic [7:0] drv_o;
	logic [7:0] ctl_o;
	logic [7:0] pulses;
	logic [7:0] p;
	logic [15:0] rx;
	logic [7:0] exp_rd [9];
	int         failures;
	int         tests_run;
	int         i;

	assign drv_o = {output_swing_sel, output_common_mode_level, deemph_en, deemph_level, 1'b0};
	assign ctl_o = {3'b000, out_mute, eq_bypass, eq_sleep, launch_atten_sel, adapt_reset};

	eqcr_host_model eqcr_host_model_i (.core_clk(core_clk), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso));

	eqcr_regs eqcr_regs_i (.core_clk(core_clk), .rst(rst), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .carrier_detect(carrier_detect), .rate_is_hd(rate_is_hd),
		.cable_length_code(cable_length_code), .launch_level_code(launch_level_code),
		.mute_ref_pin_mute(mute_ref_pin_mute), .out_mute(out_mute), .eq_bypass(eq_bypass), .eq_sleep(eq_sleep),
		.adapt_reset(adapt_reset), .output_swing_sel(output_swing_sel),
		.output_common_mode_level(output_common_mode_level), .deemph_en(deemph_en),
		.deemph_level(deemph_level), .launch_atten_sel(launch_atten_sel));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Counts adaptation reset pulses
	always @(posedge core_clk) begin
		if (rst === 1'b1) pulses <= 8'h00;
		else if (adapt_reset === 1'b1) pulses <= pulses + 8'h01;
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		eqcr_host_model_i.sel();
		eqcr_host_model_i.shift({1'b0, a, d}, 16, rx);
		eqcr_host_model_i.desel();
		repeat (3) @(posedge core_clk);
	endtask

	// Read frame, then an all-ones frame returns address echo and data
	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		eqcr_host_model_i.sel();
		eqcr_host_model_i.shift({1'b1, a, 8'hff}, 16, rx);
		eqcr_host_model_i.desel();
		eqcr_host_model_i.sel();
		eqcr_host_model_i.shift(16'hffff, 16, rx);
		eqcr_host_model_i.desel();
		chk($sformatf("echo %h", a), {1'b1, a}, rx[15:8]);
		chk($sformatf("reg %h", a), exp, rx[7:0]);
	endtask

	task automatic settle();
		repeat (4) @(posedge core_clk);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		carrier_detect = 1'b1;
		rate_is_hd = 1'b1;
		cable_length_code = 8'hf7;
		launch_level_code = 6'h20;
		mute_ref_pin_mute = 1'b0;
		exp_rd = '{8'h88, 8'ha2, 8'h68, 8'h1f, 8'h25, 8'h38, 8'hf7, 8'h80, 8'h00};
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		settle();
		chk("drive fields", 8'ha2, drv_o);
		chk("control outs", 8'h00, ctl_o);
		for (i = 0; i < 9; i++) rchk(i[6:0], exp_rd[i]);
		carrier_detect <= 1'b0;
		settle();
		chk("auto sleep", 8'h04, ctl_o);
		rchk(7'h00, 8'h08);
		for (i = 0; i < 4; i++) begin
			wr(7'h00, {3'b000, i[1:0], 3'b000});
			chk("sleep code", (i == 1 || i == 2) ? 8'h04 : 8'h00, ctl_o);
		end
		carrier_detect <= 1'b1;
		wr(7'h00, 8'h40);
		chk("mute", 8'h10, ctl_o);
		wr(7'h00, 8'h20);
		chk("bypass", 8'h08, ctl_o);
		wr(7'h00, 8'h60);
		chk("mute over bypass", 8'h01, {7'h00, out_mute});
		wr(7'h00, 8'h70);
		chk("sleep first", 8'h01, {7'h00, eq_sleep});
		p = pulses;
		wr(7'h00, 8'h41);
		chk("acq pulse", p + 8'h01, pulses);
		rchk(7'h00, 8'hc0);
		for (i = 0; i < 4; i++) begin
			wr(7'h01, {i[1:0], i[1:0], 1'b1, i[1:0], 1'b1});
			chk("drive set", {i[1:0], i[1:0], 1'b1, i[1:0], 1'b0}, drv_o);
			rchk(7'h01, {i[1:0], i[1:0], 1'b1, i[1:0], 1'b0});
		end
		wr(7'h02, 8'he8);
		chk("atten", 8'h01, {7'h00, launch_atten_sel});
		rchk(7'h02, 8'he8);
		wr(7'h00, 8'h00);
		mute_ref_pin_mute <= 1'b1;
		settle();
		chk("pin mute", 8'h01, {7'h00, out_mute});
		mute_ref_pin_mute <= 1'b0;
		wr(7'h03, 8'h20);
		cable_length_code <= 8'h08;
		settle();
		chk("thr 0 at 08", 8'h01, {7'h00, out_mute});
		cable_length_code <= 8'h07;
		settle();
		chk("thr 0 at 07", 8'h00, {7'h00, out_mute});
		wr(7'h03, 8'h2f);
		cable_length_code <= 8'h80;
		settle();
		chk("thr f at 80", 8'h01, {7'h00, out_mute});
		cable_length_code <= 8'h7f;
		settle();
		chk("thr f at 7f", 8'h00, {7'h00, out_mute});
		wr(7'h03, 8'h3f);
		cable_length_code <= 8'hff;
		settle();
		chk("never mute", 8'h00, {7'h00, out_mute});
		wr(7'h06, 8'h00);
		wr(7'h04, 8'h00);
		rchk(7'h06, 8'hff);
		rchk(7'h04, 8'h25);
		eqcr_host_model_i.sel();
		eqcr_host_model_i.shift(16'h0100, 8, rx);
		eqcr_host_model_i.desel();
		rchk(7'h01, 8'hfe);
		eqcr_host_model_i.sel();
		eqcr_host_model_i.shift(16'h0100, 16, rx);
		settle();
		chk("before select", 8'hfe, drv_o);
		eqcr_host_model_i.desel();
		settle();
		chk("after select", 8'h00, drv_o);
		wr(7'h03, 8'h25);
		p = pulses;
		wr(7'h00, 8'h02);
		chk("master pulse", p + 8'h01, pulses);
		chk("master drive", 8'ha2, drv_o);
		rchk(7'h03, 8'h1f);
		rchk(7'h02, 8'h68);
		rchk(7'h00, 8'h88);
		rate_is_hd <= 1'b0;
		rchk(7'h05, 8'h18);
		end_of_test();
	end
endmodule
